// ### logic/ube_bulk_engine.sv
// bulk-in transmitter, bulk-out receiver and their AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
module ube_bulk_engine #(
  parameter int US_CYCLES = ube_pkg::CYC_PER_US
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic in_token,
  input wire logic in_ack,
  input wire logic in_timeout,
  input wire logic in_halt,
  output logic in_resp_valid,
  output var ube_pkg::ube_in_type in_resp,
  output logic in_toggle,
  output logic in_beat_valid,
  output var ube_pkg::ube_beat_type in_beat,
  input wire logic [15:0] rx_level,
  input wire logic [7:0] rx_frames,
  input wire logic [31:0] rx_head,
  output logic rx_pop,
  output logic rx_rewind,
  output logic rx_advance,
  input wire logic out_ping,
  input wire logic out_end,
  input wire logic out_crc_bad,
  input wire logic out_halt_clr,
  input wire logic fifo_sync_lost,
  input wire logic [15:0] tx_free,
  output logic out_hs_valid,
  output var ube_pkg::ube_hs_type out_hs,
  output logic tx_rewind,
  output logic out_stalled
);
  if (US_CYCLES < 1) begin : g_bad_us
    $error("US_CYCLES must be at least one");
  end

  function automatic logic [3:0] be_of(input logic [2:0] n);
    be_of = (n >= 3'd4) ? 4'hF : 4'((5'd1 << n) - 5'd1);
  endfunction : be_of

  // ------------------------------
  // register bus
  // ------------------------------
  ube_pkg::ube_cfg_type cfg_r;
  logic ap_wr_r;
  logic [11:0] ap_addr_r;
  logic [31:0] hrdata_r;
  logic rd_wait_r;
  logic [31:0] status_word;
  logic ap_take;

  assign ap_take = hsel && htrans[1] && hready;
  assign hreadyout = !rd_wait_r;
  assign hrdata = hrdata_r;
  assign hresp = 1'b0;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= 12'h000;
    end else if (hready) begin
      ap_wr_r <= ap_take && hwrite && hsize == 3'b010;
      ap_addr_r <= {haddr[11:2], 2'b00};
    end
  end

  // one wait state so read data always comes from a flop
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_wait_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      rd_wait_r <= ap_take && !hwrite;
      if (rd_wait_r) begin
        unique case (ap_addr_r)
          ube_pkg::REG_CFG: hrdata_r <= {22'h00_0000, cfg_r.off, 3'b000, cfg_r.csum,
            cfg_r.out_stall_dis, cfg_r.ers, cfg_r.cap_en, cfg_r.multi};
          ube_pkg::REG_DLY: hrdata_r <= {16'h0000, cfg_r.delay};
          ube_pkg::REG_CAP: hrdata_r <= {24'h00_0000, cfg_r.cap};
          ube_pkg::REG_STAT: hrdata_r <= status_word;
          default: hrdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_r.multi <= ube_pkg::CFG_RST[ube_pkg::CFG_MULTI_BIT];
      cfg_r.cap_en <= ube_pkg::CFG_RST[ube_pkg::CFG_CAP_EN_BIT];
      cfg_r.ers <= ube_pkg::CFG_RST[ube_pkg::CFG_ERS_BIT];
      cfg_r.out_stall_dis <= ube_pkg::CFG_RST[ube_pkg::CFG_OSD_BIT];
      cfg_r.csum <= ube_pkg::CFG_RST[ube_pkg::CFG_CSUM_BIT];
      cfg_r.off <= ube_pkg::CFG_RST[ube_pkg::CFG_OFF_LSB +: 2];
      cfg_r.delay <= ube_pkg::DLY_RST;
      cfg_r.cap <= ube_pkg::CAP_RST;
    end else if (ap_wr_r) begin
      if (ap_addr_r == ube_pkg::REG_CFG) begin
        cfg_r.multi <= hwdata[ube_pkg::CFG_MULTI_BIT];
        cfg_r.cap_en <= hwdata[ube_pkg::CFG_CAP_EN_BIT];
        cfg_r.ers <= hwdata[ube_pkg::CFG_ERS_BIT];
        cfg_r.out_stall_dis <= hwdata[ube_pkg::CFG_OSD_BIT];
        cfg_r.csum <= hwdata[ube_pkg::CFG_CSUM_BIT];
        cfg_r.off <= hwdata[ube_pkg::CFG_OFF_LSB +: 2];
      end
      if (ap_addr_r == ube_pkg::REG_DLY) cfg_r.delay <= hwdata[15:0];
      if (ap_addr_r == ube_pkg::REG_CAP) cfg_r.cap <= hwdata[7:0];
    end
  end

  // ------------------------------
  // bulk-in delay timer
  // ------------------------------
  logic [15:0] us_cnt_r;
  logic us_tick;
  logic [15:0] tmr_r;
  logic tmr_run_r;
  logic tmr_done_r;
  logic tmr_start;
  logic tmr_clear;

  assign us_tick = us_cnt_r == 16'(US_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (!resetn) us_cnt_r <= 16'h0000;
    else if (us_tick || tmr_start) us_cnt_r <= 16'h0000;
    else us_cnt_r <= us_cnt_r + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tmr_r <= 16'h0000;
      tmr_run_r <= 1'b0;
      tmr_done_r <= 1'b0;
    end else if (tmr_start) begin
      tmr_r <= cfg_r.delay;
      tmr_run_r <= 1'b1;
      tmr_done_r <= 1'b0;
    end else if (tmr_clear) begin
      tmr_run_r <= 1'b0;
      tmr_done_r <= 1'b0;
    end else if (tmr_run_r && us_tick) begin
      tmr_r <= tmr_r - 16'h0001;
      if (tmr_r <= 16'h0001) begin
        tmr_run_r <= 1'b0;
        tmr_done_r <= 1'b1;
      end
    end
  end

  // ------------------------------
  // bulk-in packet builder
  // ------------------------------
  typedef enum logic {UBE_ST_IDLE, UBE_ST_SEND} ube_st_type;
  ube_st_type st_r;
  logic [15:0] rem_r;
  logic [15:0] snap_rem_r;
  logic [9:0] pkt_r;
  logic [9:0] limit_r;
  logic [9:0] last_len_r;
  logic unacked_r;
  logic aligned_end_r;
  logic zlp_pend_r;
  logic [16:0] burst_r;
  logic cap_active;
  logic [16:0] cap_bytes;
  logic [15:0] new_total;
  logic at_start;
  logic [15:0] cur_rem;
  logic pad;
  logic [9:0] room;
  logic [9:0] cnt;
  logic [15:0] rem_next;
  logic stop;
  logic end_here;
  logic has_data;
  logic [9:0] pkt_end;

  assign cap_active = cfg_r.cap_en && cfg_r.cap > 8'(ube_pkg::CAP_MIN);
  assign cap_bytes = 17'(cfg_r.cap) << ube_pkg::CAP_UNIT_SHIFT;
  assign has_data = rx_frames != 8'h00 || rem_r != 16'h0000;

  always_comb begin
    new_total = 16'(ube_pkg::STAT_BYTES) + 16'(cfg_r.off)
      + 16'(rx_head[ube_pkg::STAT_LEN_LSB +: ube_pkg::STAT_LEN_W])
      + (cfg_r.csum ? 16'(ube_pkg::CSUM_BYTES) : 16'h0000);
    at_start = rem_r == 16'h0000;
    cur_rem = at_start ? new_total : rem_r;
    // pad only in multi mode with a frame behind
    pad = cur_rem < 16'h0004 && cfg_r.multi && rx_frames > 8'h01;
    room = limit_r - pkt_r;
    cnt = (pad || cur_rem >= 16'h0004) ? 10'h004 : 10'(cur_rem);
    if (cnt > room) cnt = room;
    rem_next = (16'(cnt) >= cur_rem) ? 16'h0000 : cur_rem - 16'(cnt);
    pkt_end = pkt_r + cnt;
    stop = pkt_r >= limit_r || (!at_start && rx_level == 16'h0000)
      || (at_start && (rx_frames == 8'h00 || (!cfg_r.multi && pkt_r != 10'h000)
      || (cap_active && burst_r + 17'(pkt_r) + 17'(new_total) > cap_bytes)));
    // packet ends at 512 bytes, frame resumes next packet
    end_here = pkt_end >= limit_r || (cur_rem < 16'h0004 && !pad)
      || (!cfg_r.multi && rem_next == 16'h0000);
  end

  assign rx_pop = st_r == UBE_ST_SEND && !stop;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= UBE_ST_IDLE;
      rem_r <= 16'h0000;
      snap_rem_r <= 16'h0000;
      pkt_r <= 10'h000;
      limit_r <= 10'(ube_pkg::MAX_PKT_BYTES);
      last_len_r <= 10'h000;
      unacked_r <= 1'b0;
      aligned_end_r <= 1'b0;
      in_resp_valid <= 1'b0;
      in_resp <= ube_pkg::UBE_IN_NAK;
      in_beat_valid <= 1'b0;
      in_beat <= '0;
    end else begin
      in_resp_valid <= 1'b0;
      in_beat_valid <= 1'b0;
      unique case (st_r)
        UBE_ST_IDLE: begin
          if (in_token) begin
            in_resp_valid <= 1'b1;
            snap_rem_r <= rem_r;
            pkt_r <= 10'h000;
            limit_r <= 10'(ube_pkg::MAX_PKT_BYTES);
            if (in_halt) in_resp <= ube_pkg::UBE_IN_STALL;
            else if (unacked_r && last_len_r == 10'h000) in_resp <= ube_pkg::UBE_IN_ZLP;
            else if (unacked_r) begin
              in_resp <= ube_pkg::UBE_IN_DATA;
              limit_r <= last_len_r;
              st_r <= UBE_ST_SEND;
            end
            // full packet may go, else NACK while waiting
            else if (tmr_run_r && rx_level < 16'(ube_pkg::MAX_PKT_BYTES))
              in_resp <= ube_pkg::UBE_IN_NAK;
            else if (zlp_pend_r) begin
              in_resp <= ube_pkg::UBE_IN_ZLP;
              last_len_r <= 10'h000;
              unacked_r <= 1'b1;
            end else if (has_data && tmr_start) in_resp <= ube_pkg::UBE_IN_NAK;
            else if (has_data) begin
              in_resp <= ube_pkg::UBE_IN_DATA;
              st_r <= UBE_ST_SEND;
            end
            else if (cap_active || !cfg_r.ers) begin
              in_resp <= ube_pkg::UBE_IN_ZLP;
              last_len_r <= 10'h000;
              unacked_r <= 1'b1;
            end else in_resp <= ube_pkg::UBE_IN_NAK;
          end else if (in_timeout && unacked_r && last_len_r != 10'h000) begin
            // rewind the packet builder with the FIFO
            rem_r <= snap_rem_r;
          end
        end
        UBE_ST_SEND: begin
          in_beat_valid <= 1'b1;
          if (stop) begin
            in_beat <= '{data: 32'h0000_0000, be: 4'h0, last: 1'b1};
            last_len_r <= pkt_r;
            aligned_end_r <= at_start;
            unacked_r <= 1'b1;
            st_r <= UBE_ST_IDLE;
          end else begin
            in_beat <= '{data: rx_head, be: be_of(cnt[2:0]), last: end_here};
            pkt_r <= pkt_end;
            rem_r <= rem_next;
            if (end_here) begin
              last_len_r <= pkt_end;
              aligned_end_r <= rem_next == 16'h0000;
              unacked_r <= 1'b1;
              st_r <= UBE_ST_IDLE;
            end
          end
        end
      endcase
      if (in_ack && st_r == UBE_ST_IDLE) unacked_r <= 1'b0;
    end
  end

  // delay starts on a lone short frame or after a full packet ack
  assign tmr_start = cfg_r.multi && cfg_r.delay != 16'h0000 && !tmr_done_r
    && rx_level < 16'(ube_pkg::MAX_PKT_BYTES) && st_r == UBE_ST_IDLE
    && ((in_token && !in_halt && !unacked_r && !tmr_run_r && !zlp_pend_r && has_data)
    || (in_ack && unacked_r && last_len_r == 10'(ube_pkg::MAX_PKT_BYTES)));

  // ------------------------------
  // burst accounting and acknowledgement
  // ------------------------------
  logic ack_ok;
  assign ack_ok = in_ack && unacked_r && st_r == UBE_ST_IDLE;
  assign tmr_clear = ack_ok && last_len_r < 10'(ube_pkg::MAX_PKT_BYTES);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      burst_r <= 17'h0_0000;
      zlp_pend_r <= 1'b0;
      in_toggle <= 1'b0;
      rx_advance <= 1'b0;
      rx_rewind <= 1'b0;
    end else begin
      rx_advance <= 1'b0;
      rx_rewind <= 1'b0;
      if (ack_ok) begin
        in_toggle <= !in_toggle;
        // ack lets the FIFO move on
        rx_advance <= last_len_r != 10'h000;
        if (last_len_r < 10'(ube_pkg::MAX_PKT_BYTES)) begin
          burst_r <= 17'h0_0000;
          zlp_pend_r <= 1'b0;
        end else begin
          burst_r <= burst_r + 17'(last_len_r);
          if (!cfg_r.multi && aligned_end_r) zlp_pend_r <= 1'b1;
          if (cap_active && burst_r + 17'(last_len_r) > cap_bytes) zlp_pend_r <= 1'b1;
          // multi-frame burst ran dry on a full packet
          if (cfg_r.multi && rx_frames == 8'h00 && rem_r == 16'h0000) zlp_pend_r <= 1'b1;
        end
      end
      // no ack: FIFO rewinds for retransmission
      if (in_timeout && unacked_r && last_len_r != 10'h000 && st_r == UBE_ST_IDLE)
        rx_rewind <= 1'b1;
    end
  end

  // ------------------------------
  // bulk-out receiver
  // ------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) out_stalled <= 1'b0;
    // sync loss stall, set wins over clear
    else if (fifo_sync_lost && !cfg_r.out_stall_dis) out_stalled <= 1'b1;
    else if (out_halt_clr) out_stalled <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_hs_valid <= 1'b0;
      out_hs <= ube_pkg::UBE_HS_NAK;
      tx_rewind <= 1'b0;
    end else begin
      out_hs_valid <= 1'b0;
      tx_rewind <= 1'b0;
      if (out_ping) begin
        out_hs_valid <= 1'b1;
        if (out_stalled) out_hs <= ube_pkg::UBE_HS_STALL;
        else if (tx_free >= 16'(ube_pkg::NYET_ROOM_BYTES)) out_hs <= ube_pkg::UBE_HS_ACK;
        else out_hs <= ube_pkg::UBE_HS_NAK;
      end else if (out_end) begin
        if (out_crc_bad) tx_rewind <= 1'b1;
        else begin
          out_hs_valid <= 1'b1;
          if (out_stalled) begin
            out_hs <= ube_pkg::UBE_HS_STALL;
            tx_rewind <= 1'b1;
          end
          else if (tx_free >= 16'(ube_pkg::ACK_ROOM_BYTES)) out_hs <= ube_pkg::UBE_HS_ACK;
          else if (tx_free >= 16'(ube_pkg::NYET_ROOM_BYTES)) out_hs <= ube_pkg::UBE_HS_NYET;
          else begin
            out_hs <= ube_pkg::UBE_HS_NAK;
            tx_rewind <= 1'b1;
          end
        end
      end
    end
  end

  assign status_word = {burst_r, 10'h000, out_stalled, unacked_r, zlp_pend_r,
    tmr_done_r, tmr_run_r};
endmodule : ube_bulk_engine
`default_nettype wire

// ### logic/ube_pkg.sv
// constants and types of the bulk endpoint engine
// Behaviour
// - multi-frame packing packs several frames per bulk-in packet; otherwise one frame each.
// - frames longer than 512 bytes are split over successive bulk-in packets.
// - each frame begins with a status word whose length field delimits it.
// - nonzero rx data offset inserts that many pad bytes after the status word.
// - a burst ends with a short packet, or a ZLP after exact multiples.
// - single-frame mode sends a ZLP after frames that fill whole packets.
// - multi-frame frames start word aligned; pad only when another frame follows.
// - single-frame mode never pads; transfer ends on the last frame byte.
// - an IN token with an empty receive FIFO gets a zero-length packet, or a NACK when select is 1 with cap off.
// - an unacknowledged short packet or ZLP is repeated unchanged until acknowledged.
// - multi-frame burst end waits the programmed delay; zero disables; default 34 us.
// - delay starts after last full packet or lone short frame; full packets restart it.
// - tokens during the delay are NACKed regardless of the empty-response setting; the code sends data when a full packet is waiting.
// - with cap enabled and above 4, exceeding cap*512 bytes forces a ZLP.
// - with cap off, empty answers are ZLP when select is 0, NACK when 1.
// - capped bursts end by the cap or a dry FIFO; frames never split.
// - an unacknowledged packet rewinds the FIFO and is resent; ack advances it.
// - the bulk-in endpoint stalls only when the host has halted it.
// - bulk-out answers ACK, NYET or NACK by free space; PING supported.
// - corrupted bulk-out packets get no handshake and are rewound; host resends.
// - loss of frame sync stalls the bulk-out pipe unless stalling is disabled.
package ube_pkg;
  // ------------------------------
  // sizes and timing
  // ------------------------------
  localparam int MAX_PKT_BYTES = 512;
  localparam int ACK_ROOM_BYTES = 1024;
  localparam int NYET_ROOM_BYTES = 512;
  localparam int STAT_BYTES = 4;
  localparam int CSUM_BYTES = 4;
  localparam int CAP_MIN = 4;
  localparam int CAP_UNIT_SHIFT = 9;
  localparam int CLK_PERIOD_NS = 5;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_DEFAULT_US = 34;
  localparam int STAT_LEN_LSB = 16;
  localparam int STAT_LEN_W = 14;
  // ------------------------------
  // register map
  // ------------------------------
  localparam logic [11:0] REG_CFG = 12'h000;
  localparam logic [11:0] REG_DLY = 12'h004;
  localparam logic [11:0] REG_CAP = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00C;
  localparam int CFG_MULTI_BIT = 0;
  localparam int CFG_CAP_EN_BIT = 1;
  localparam int CFG_ERS_BIT = 2;
  localparam int CFG_OSD_BIT = 3;
  localparam int CFG_CSUM_BIT = 4;
  localparam int CFG_OFF_LSB = 8;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [15:0] DLY_RST = 16'h0022;
  localparam logic [7:0] CAP_RST = 8'h00;
  // ------------------------------
  // types
  // ------------------------------
  typedef enum logic [1:0] {UBE_HS_ACK, UBE_HS_NAK, UBE_HS_NYET, UBE_HS_STALL} ube_hs_type;
  typedef enum logic [1:0] {UBE_IN_NAK, UBE_IN_STALL, UBE_IN_ZLP, UBE_IN_DATA} ube_in_type;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] be;
    logic last;
  } ube_beat_type;
  typedef struct packed {
    logic multi;
    logic cap_en;
    logic ers;
    logic out_stall_dis;
    logic csum;
    logic [1:0] off;
    logic [15:0] delay;
    logic [7:0] cap;
  } ube_cfg_type;
endpackage : ube_pkg

// ### verif/ube_bulk_engine_assertions.sv
// port-level assertion checker of the bulk endpoint engine
`timescale 1ns/100ps
`default_nettype none
module ube_bulk_engine_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_token,
  input wire logic in_ack,
  input wire logic in_timeout,
  input wire logic in_halt,
  input wire logic in_resp_valid,
  input wire ube_pkg::ube_in_type in_resp,
  input wire logic in_toggle,
  input wire logic in_beat_valid,
  input wire ube_pkg::ube_beat_type in_beat,
  input wire logic rx_rewind,
  input wire logic out_ping,
  input wire logic out_end,
  input wire logic out_crc_bad,
  input wire logic fifo_sync_lost,
  input wire logic [15:0] tx_free,
  input wire logic out_hs_valid,
  input wire ube_pkg::ube_hs_type out_hs,
  input wire logic tx_rewind,
  input wire logic out_stalled
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic [7:0] beat_cnt_r;
  logic out_plain;
  // a stall takes over the answer and sync loss only sets the stall a cycle later, so leave both out
  assign out_plain = out_end && !out_ping && !out_crc_bad && !out_stalled && !fifo_sync_lost;
  always_ff @(posedge clk) begin
    if (!resetn || (in_beat_valid && in_beat.last)) begin
      beat_cnt_r <= 8'h00;
    end else if (in_beat_valid) begin
      beat_cnt_r <= beat_cnt_r + 8'h01;
    end
  end
  sequence s_data_start;
    in_resp_valid && in_resp == ube_pkg::UBE_IN_DATA;
  endsequence
  sequence s_other_start;
    in_resp_valid && in_resp != ube_pkg::UBE_IN_DATA;
  endsequence
  resp_follows_token_a: assert property (in_resp_valid |-> $past(in_token))
    else $error("bulk-in answer without token");
  stall_by_host_a: assert property (
    in_resp_valid |-> ((in_resp == ube_pkg::UBE_IN_STALL) == $past(in_halt)))
    else $error("bulk-in stall not tied to host halt");
  empty_no_beats_a: assert property (s_other_start |=> !in_beat_valid)
    else $error("beats after a data-less answer");
  data_then_beats_a: assert property (s_data_start |=> in_beat_valid)
    else $error("data answer without beats");
  pkt_max_len_a: assert property (in_beat_valid |-> beat_cnt_r < 8'h80)
    else $error("bulk-in packet over 512 bytes");
  ack_flips_toggle_a: assert property (in_ack |=> in_toggle != $past(in_toggle))
    else $error("toggle kept after ack");
  miss_rewinds_a: assert property (in_timeout |=> rx_rewind)
    else $error("no rewind after missed ack");
  out_ack_a: assert property (
    out_plain && tx_free >= 16'h0400 |=> out_hs_valid && out_hs == ube_pkg::UBE_HS_ACK)
    else $error("out ack expected");
  out_nyet_a: assert property (out_plain && tx_free >= 16'h0200 && tx_free < 16'h0400
    |=> out_hs_valid && out_hs == ube_pkg::UBE_HS_NYET)
    else $error("out nyet expected");
  out_nak_a: assert property (out_plain && tx_free < 16'h0200
    |=> out_hs_valid && out_hs == ube_pkg::UBE_HS_NAK && tx_rewind)
    else $error("out nak expected");
  crc_silent_a: assert property (
    out_end && out_crc_bad && !out_ping |=> tx_rewind && !out_hs_valid)
    else $error("bad out packet answered");
  stall_by_sync_a: assert property ($rose(out_stalled) |-> $past(fifo_sync_lost))
    else $error("out stall without sync loss");
endmodule : ube_bulk_engine_chk
`default_nettype wire

// ### verif/ube_rx_fifo_model.sv
// behavioural receive FIFO that feeds the bulk-in transmitter
`timescale 1ns/100ps
`default_nettype none
module ube_rx_fifo_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic push,
  input wire logic [31:0] push_data,
  input wire logic rx_pop,
  input wire logic rx_rewind,
  input wire logic rx_advance,
  output logic [15:0] rx_level,
  output logic [31:0] rx_head
);
  logic [31:0] mem [64];
  logic [31:0] junk_r;
  logic [5:0] wr_r, rd_r, cm_r;
  always_ff @(posedge clk) if (push) mem[wr_r] <= push_data;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_r <= 6'h00;
      rd_r <= 6'h00;
      cm_r <= 6'h00;
      junk_r <= 32'hA5A5_A5A5;
    end else begin
      junk_r <= ~junk_r;
      wr_r <= wr_r + {5'h00, push};
      if (rx_rewind) rd_r <= cm_r;
      else if (rx_pop) rd_r <= rd_r + 6'h01;
      if (rx_advance) cm_r <= rd_r;
    end
  end
  // empty head shows a changing pattern, never a stale word
  assign rx_head = (rd_r == wr_r) ? junk_r : mem[rd_r];
  assign rx_level = {8'h00, wr_r - rd_r, 2'b00};
endmodule : ube_rx_fifo_model
`default_nettype wire

// ### verif/usb_bulk_endpoint_engine_test.sv
// self-checking bench of the bulk endpoint engine
`timescale 1ns/100ps
`default_nettype none
module usb_bulk_endpoint_engine_test;
  logic clk = 1'b0;
  logic resetn, hsel, hwrite, hready, hreadyout, hresp, push;
  logic [31:0] haddr, hwdata, hrdata, rx_head, push_data;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic in_token, in_ack, in_timeout, in_halt, in_resp_valid, in_toggle, in_beat_valid;
  ube_pkg::ube_in_type in_resp;
  ube_pkg::ube_beat_type in_beat;
  ube_pkg::ube_beat_type got[$];
  logic [15:0] rx_level, tx_free;
  logic [7:0] rx_frames;
  logic rx_pop, rx_rewind, rx_advance, out_ping, out_end, out_crc_bad, out_halt_clr;
  logic fifo_sync_lost, out_hs_valid, tx_rewind, out_stalled;
  ube_pkg::ube_hs_type out_hs;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  assign hready = hreadyout;
  ube_bulk_engine #(.US_CYCLES(2)) uut (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .in_token, .in_ack, .in_timeout,
    .in_halt, .in_resp_valid, .in_resp, .in_toggle, .in_beat_valid, .in_beat, .rx_level,
    .rx_frames, .rx_head, .rx_pop, .rx_rewind, .rx_advance, .out_ping, .out_end,
    .out_crc_bad, .out_halt_clr, .fifo_sync_lost, .tx_free, .out_hs_valid, .out_hs,
    .tx_rewind, .out_stalled);
  ube_rx_fifo_model u_fifo (.clk, .resetn, .push, .push_data, .rx_pop, .rx_rewind,
    .rx_advance, .rx_level, .rx_head);
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] e);
    n_compared++;
    if (seen !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, e, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string s);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(s, q, e);
    chk("okay resp", hresp, 1'b0);
  endtask : rd
  // bits: ack, timeout, ping, out end, sync lost, halt clear
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    {in_ack, in_timeout, out_ping, out_end, fifo_sync_lost, out_halt_clr} <= m;
    @(posedge clk);
    {in_ack, in_timeout, out_ping, out_end, fifo_sync_lost, out_halt_clr} <= 6'h00;
  endtask : pulse
  // status word then numbered frame words
  task automatic load(input logic [13:0] len, input int words);
    for (int i = 0; i <= words; i++) begin
      @(posedge clk);
      push <= 1'b1;
      push_data <= (i == 0) ? {2'b00, len, 16'h0000} : 32'h1000_0000 + i;
    end
    @(posedge clk);
    push <= 1'b0;
    rx_frames <= 8'h01;
  endtask : load
  task automatic token(input ube_pkg::ube_in_type e);
    int k;
    got.delete();
    @(posedge clk);
    in_token <= 1'b1;
    @(posedge clk);
    in_token <= 1'b0;
    for (k = 0; k < 8 && in_resp_valid !== 1'b1; k++)
      @(posedge clk);
    chk("resp valid", in_resp_valid, 1'b1);
    chk("resp code", in_resp, e);
    while (e == ube_pkg::UBE_IN_DATA && k < 300 && !(got.size() > 0 && got[$].last)) begin
      @(posedge clk);
      k++;
      if (in_beat_valid === 1'b1) got.push_back(in_beat);
    end
  endtask : token
  task automatic chk_frame(input logic [3:0] be);
    chk("beat count", got.size(), 3);
    chk("status word", got[0].data, 32'h0006_0000);
    chk("frame word", got[1].data, 32'h1000_0001);
    chk("end bytes", got[2].be, be);
    chk("end mark", got[2].last, 1'b1);
  endtask : chk_frame
  task automatic out_chk(input logic [5:0] m, input logic [15:0] f, input logic crc,
                         input logic v, input ube_pkg::ube_hs_type hs, input logic rw);
    tx_free <= f;
    out_crc_bad <= crc;
    pulse(m);
    @(posedge clk);
    chk("hs valid", out_hs_valid, v);
    if (v) chk("hs code", out_hs, hs);
    chk("out rewind", tx_rewind, rw);
  endtask : out_chk
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic sc_regs();
    rd(ube_pkg::REG_CFG, ube_pkg::CFG_RST, "cfg reset");
    rd(ube_pkg::REG_DLY, 32'h0000_0022, "delay reset");
    rd(ube_pkg::REG_CAP, 32'h0000_0000, "cap reset");
    wr(12'h010, 32'hFFFF_FFFF);
    rd(12'h010, 32'h0000_0000, "unmapped");
    wr(ube_pkg::REG_CAP, 32'h0000_0009);
    rd(ube_pkg::REG_CAP, 32'h0000_0009, "cap");
    wr(ube_pkg::REG_CAP, 32'h0000_0000);
  endtask : sc_regs
  task automatic sc_single();
    logic t0;
    token(ube_pkg::UBE_IN_ZLP);
    load(14'h0006, 2);
    token(ube_pkg::UBE_IN_ZLP);
    t0 = in_toggle;
    pulse(6'h20);
    @(posedge clk);
    chk("toggle", in_toggle, !t0);
    token(ube_pkg::UBE_IN_DATA);
    chk_frame(4'h3);
    pulse(6'h10);
    token(ube_pkg::UBE_IN_DATA);
    chk_frame(4'h3);
    pulse(6'h20);
    rx_frames <= 8'h00;
  endtask : sc_single
  task automatic sc_empty();
    wr(ube_pkg::REG_CFG, 32'h0000_0006);
    token(ube_pkg::UBE_IN_NAK);
    in_halt <= 1'b1;
    token(ube_pkg::UBE_IN_STALL);
    in_halt <= 1'b0;
  endtask : sc_empty
  task automatic sc_delay();
    wr(ube_pkg::REG_CFG, 32'h0000_0101);
    wr(ube_pkg::REG_DLY, 32'h0000_0014);
    load(14'h0006, 2);
    token(ube_pkg::UBE_IN_NAK);
    token(ube_pkg::UBE_IN_NAK);
    repeat (100) @(posedge clk);
    token(ube_pkg::UBE_IN_DATA);
    chk_frame(4'h7);
    pulse(6'h20);
    rx_frames <= 8'h00;
  endtask : sc_delay
  task automatic sc_out();
    logic [15:0] fr[3] = '{16'h0800, 16'h0258, 16'h0064};
    ube_pkg::ube_hs_type hs[3] = '{ube_pkg::UBE_HS_ACK, ube_pkg::UBE_HS_NYET,
                                   ube_pkg::UBE_HS_NAK};
    for (int i = 0; i < 3; i++) begin
      out_chk(6'h04, fr[i], 1'b0, 1'b1, hs[i], i == 2);
    end
    out_chk(6'h04, 16'h0800, 1'b1, 1'b0, ube_pkg::UBE_HS_ACK, 1'b1);
    out_chk(6'h04, 16'h0800, 1'b0, 1'b1, ube_pkg::UBE_HS_ACK, 1'b0);
    out_chk(6'h08, 16'h0258, 1'b0, 1'b1, ube_pkg::UBE_HS_ACK, 1'b0);
    pulse(6'h02);
    out_chk(6'h04, 16'h0800, 1'b0, 1'b1, ube_pkg::UBE_HS_STALL, 1'b1);
    chk("stalled", out_stalled, 1'b1);
    pulse(6'h01);
    wr(ube_pkg::REG_CFG, 32'h0000_0008);
    pulse(6'h02);
    @(posedge clk);
    chk("stall off", out_stalled, 1'b0);
  endtask : sc_out
  initial begin
    {hsel, hwrite, in_token, in_halt, push, out_crc_bad} = '0;
    {in_ack, in_timeout, out_ping, out_end, fifo_sync_lost, out_halt_clr} = '0;
    {haddr, hwdata, push_data} = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    tx_free = 16'h0000;
    rx_frames = 8'h00;
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    sc_regs();
    sc_single();
    sc_empty();
    sc_delay();
    sc_out();
    wrap_up();
  end
endmodule : usb_bulk_endpoint_engine_test
bind ube_bulk_engine ube_bulk_engine_chk u_chk (.clk, .resetn, .in_token, .in_ack,
  .in_timeout, .in_halt, .in_resp_valid, .in_resp, .in_toggle, .in_beat_valid, .in_beat,
  .rx_rewind, .out_ping, .out_end, .out_crc_bad, .fifo_sync_lost, .tx_free, .out_hs_valid,
  .out_hs, .tx_rewind, .out_stalled);
`default_nettype wire
